// file: logic/fbo_host.sv
// Host that drives a byte-wide flash through its bus pins.
// Assumes the flash samples the pins asynchronously; all pins change
// on clk_i edges only. The data pin is split into in, out and enable.
module fbo_host
    import fbo_pkg::*;
#(
    parameter bit HAS_INIT_PIN = 1'b1  // Flash variant has the init pin
) (
    input  wire logic       clk_i,             // 40 MHz clock
    input  wire logic       rst_i,             // Async reset, high
    input  wire logic       req_i,             // Access request
    input  wire logic       req_write_i,       // 1 write, 0 read
    input  wire logic       req_unlock_i,      // Prefix unlock writes
    input  wire fbo_addr_t  req_addr_i,        // Access address
    input  wire fbo_data_t  req_wdata_i,       // Write data
    output logic            req_ready_o,       // Request taken when high
    output fbo_data_t       rdata_o,           // Read data
    output logic            rvalid_o,          // Read data pulse
    input  wire logic       init_req_i,        // Request an init pulse
    output logic            init_done_o,       // Init pulse finished
    input  wire logic       unprotect_i,       // Want temporary unprotect
    output logic            elevated_en_o,     // Switch init to high volts
    output logic            chip_select_n_o,   // Flash select, low
    output logic            output_enable_n_o, // Flash output enable, low
    output logic            write_enable_n_o,  // Flash write enable, low
    output logic            pin_init_n_o,      // Flash init pin, low
    output fbo_addr_t       addr_in_o,         // Flash address pins
    input  wire fbo_data_t  data_io_i,         // Data pins, sensed
    output fbo_data_t       data_io_o,         // Data pins, driven
    output logic            data_io_oe_o       // Data pins driven, high
);
    import fbo_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RD, ST_WR, ST_WR_REC, ST_INIT, ST_INIT_REC
    } fbo_state_e;

    fbo_state_e state_q, state_d;
    logic       cs_n_q, cs_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic       init_n_q, init_n_d, doe_q, doe_d;
    fbo_addr_t  addr_q, addr_d, sav_addr_q, sav_addr_d;
    fbo_data_t  dout_q, dout_d, sav_data_q, sav_data_d;
    fbo_data_t  rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d, idone_q, idone_d, elev_q, elev_d;
    logic [1:0] unl_q, unl_d;

    fbo_tmr_if  tmr_if ();

    fbo_timer u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tmr   (tmr_if.tmr)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer: init pulse outranks accesses; every access starts
    // from standby so the full select access time is always waited
    always_comb begin
        state_d       = state_q;
        addr_d        = addr_q;
        dout_d        = dout_q;
        sav_addr_d    = sav_addr_q;
        sav_data_d    = sav_data_q;
        rdata_d       = rdata_q;
        unl_d         = unl_q;
        rvalid_d      = 1'b0;
        idone_d       = 1'b0;
        tmr_if.load   = 1'b0;
        tmr_if.cycles = 8'h01;
        unique case (state_q)
            ST_IDLE: begin
                if (init_req_i && HAS_INIT_PIN) begin
                    state_d       = ST_INIT;
                    tmr_if.load   = 1'b1;
                    tmr_if.cycles = CNT_W'(INIT_PULSE_CYC);
                end else if (req_i && !req_write_i) begin
                    state_d       = ST_RD;
                    addr_d        = req_addr_i;
                    tmr_if.load   = 1'b1;
                    tmr_if.cycles = CNT_W'(SEL_ACCESS_CYC);
                end else if (req_i) begin
                    state_d       = ST_WR;
                    tmr_if.load   = 1'b1;
                    tmr_if.cycles = CNT_W'(WE_PULSE_CYC);
                    sav_addr_d    = req_addr_i;
                    sav_data_d    = req_wdata_i;
                    if (req_unlock_i) begin
                        addr_d = UNLOCK_ADDR_1;
                        dout_d = UNLOCK_DATA_1;
                        unl_d  = 2'h2;
                    end else begin
                        addr_d = req_addr_i;
                        dout_d = req_wdata_i;
                        unl_d  = 2'h0;
                    end
                end
            end
            ST_RD: begin
                if (tmr_if.done) begin
                    rdata_d  = data_io_i;
                    rvalid_d = 1'b1;
                    state_d  = ST_IDLE;
                end
            end
            ST_WR: begin
                if (tmr_if.done) begin
                    state_d       = ST_WR_REC;
                    tmr_if.load   = 1'b1;
                    tmr_if.cycles = CNT_W'(WR_RECOVER_CYC);
                end
            end
            ST_WR_REC: begin
                if (tmr_if.done) begin
                    if (unl_q == 2'h0) begin
                        state_d = ST_IDLE;
                    end else begin
                        state_d       = ST_WR;
                        tmr_if.load   = 1'b1;
                        tmr_if.cycles = CNT_W'(WE_PULSE_CYC);
                        unl_d         = unl_q - 2'h1;
                        if (unl_q == 2'h2) begin
                            addr_d = UNLOCK_ADDR_2;
                            dout_d = UNLOCK_DATA_2;
                        end else begin
                            addr_d = sav_addr_q;
                            dout_d = sav_data_q;
                        end
                    end
                end
            end
            ST_INIT: begin
                if (tmr_if.done) begin
                    state_d       = ST_INIT_REC;
                    tmr_if.load   = 1'b1;
                    tmr_if.cycles = CNT_W'(INIT_RECOVER_CYC);
                end
            end
            ST_INIT_REC: begin
                if (tmr_if.done) begin
                    idone_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Pin levels follow the next state so they line up with state_q
    always_comb begin
        cs_n_d   = 1'b1;
        oe_n_d   = 1'b1;
        we_n_d   = 1'b1;
        init_n_d = 1'b1;
        doe_d    = 1'b0;
        unique case (state_d)
            ST_IDLE, ST_INIT_REC: begin
            end
            ST_RD: begin
                cs_n_d = 1'b0;
                oe_n_d = 1'b0;
            end
            ST_WR: begin
                cs_n_d = 1'b0;
                we_n_d = 1'b0;
                doe_d  = 1'b1;
            end
            ST_WR_REC: begin
                doe_d  = 1'b1;  // Data held past the write enable edge
            end
            ST_INIT: begin
                init_n_d = 1'b0;
            end
        endcase
        elev_d = unprotect_i && HAS_INIT_PIN;
    end

    ////////////////////////////////////////////////////////////////////
    // Registers: pins idle high, bus floating
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q    <= ST_IDLE;
            cs_n_q     <= 1'b1;
            oe_n_q     <= 1'b1;
            we_n_q     <= 1'b1;
            init_n_q   <= 1'b1;
            doe_q      <= 1'b0;
            addr_q     <= '0;
            dout_q     <= '0;
            sav_addr_q <= '0;
            sav_data_q <= '0;
            rdata_q    <= '0;
            rvalid_q   <= 1'b0;
            idone_q    <= 1'b0;
            elev_q     <= 1'b0;
            unl_q      <= 2'h0;
        end else begin
            state_q    <= state_d;
            cs_n_q     <= cs_n_d;
            oe_n_q     <= oe_n_d;
            we_n_q     <= we_n_d;
            init_n_q   <= init_n_d;
            doe_q      <= doe_d;
            addr_q     <= addr_d;
            dout_q     <= dout_d;
            sav_addr_q <= sav_addr_d;
            sav_data_q <= sav_data_d;
            rdata_q    <= rdata_d;
            rvalid_q   <= rvalid_d;
            idone_q    <= idone_d;
            elev_q     <= elev_d;
            unl_q      <= unl_d;
        end
    end

    // Outputs
    assign req_ready_o       = (state_q == ST_IDLE) &&
                               !(init_req_i && HAS_INIT_PIN);
    assign rdata_o           = rdata_q;
    assign rvalid_o          = rvalid_q;
    assign init_done_o       = idone_q;
    assign elevated_en_o     = elev_q;
    assign chip_select_n_o   = cs_n_q;
    assign output_enable_n_o = oe_n_q;
    assign write_enable_n_o  = we_n_q;
    assign pin_init_n_o      = init_n_q;
    assign addr_in_o         = addr_q;
    assign data_io_o         = dout_q;
    assign data_io_oe_o      = doe_q;

    ////////////////////////////////////////////////////////////////////
    // Checks: helper count of cycles with init held low
    fbo_cnt_t ilow_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ilow_q <= 8'h00;
        end else if (init_n_q) begin
            ilow_q <= 8'h00;
        end else if (ilow_q != 8'hff) begin
            ilow_q <= ilow_q + 8'h01;
        end
    end

    sequence s_rd_hold;
        (!chip_select_n_o && !output_enable_n_o && write_enable_n_o)[*4];
    endsequence
    sequence s_wr_pulse;
        (!write_enable_n_o && !chip_select_n_o && data_io_oe_o)[*2];
    endsequence

    property p_rd_levels;
        @(posedge clk_i) disable iff (rst_i)
        !output_enable_n_o |-> !chip_select_n_o && write_enable_n_o &&
            pin_init_n_o && !data_io_oe_o;
    endproperty
    a_rd_levels: assert property (p_rd_levels)
        else $error("read levels wrong");

    property p_rd_access;
        @(posedge clk_i) disable iff (rst_i)
        $fell(output_enable_n_o) |-> s_rd_hold ##1
            (rvalid_o && output_enable_n_o && chip_select_n_o);
    endproperty
    a_rd_access: assert property (p_rd_access)
        else $error("read data taken before access time");

    property p_wr_levels;
        @(posedge clk_i) disable iff (rst_i)
        $fell(write_enable_n_o) |-> s_wr_pulse ##1
            (write_enable_n_o && chip_select_n_o && output_enable_n_o &&
             data_io_oe_o);
    endproperty
    a_wr_levels: assert property (p_wr_levels)
        else $error("write pulse wrong");

    property p_standby;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_IDLE) |-> chip_select_n_o && !data_io_oe_o;
    endproperty
    a_standby: assert property (p_standby)
        else $error("not in standby while idle");

    property p_init_len;
        @(posedge clk_i) disable iff (rst_i)
        $rose(pin_init_n_o) |-> $past(ilow_q) == 8'(INIT_PULSE_CYC - 1);
    endproperty
    a_init_len: assert property (p_init_len)
        else $error("init pulse length wrong");

    property p_init_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !pin_init_n_o |-> chip_select_n_o && output_enable_n_o &&
            write_enable_n_o && !data_io_oe_o;
    endproperty
    a_init_quiet: assert property (p_init_quiet)
        else $error("bus active during init pulse");

    property p_unlock;
        @(posedge clk_i) disable iff (rst_i)
        req_i && req_ready_o && req_write_i && req_unlock_i |=> 
            addr_in_o == UNLOCK_ADDR_1 && data_io_o == UNLOCK_DATA_1
            ##3 addr_in_o == UNLOCK_ADDR_2 && data_io_o == UNLOCK_DATA_2;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock writes missing");

    property p_init_done;
        @(posedge clk_i) disable iff (rst_i)
        init_done_o |-> req_ready_o || init_req_i;
    endproperty
    a_init_done: assert property (p_init_done)
        else $error("not ready after init pulse");

    property p_variant;
        @(posedge clk_i) disable iff (rst_i)
        !HAS_INIT_PIN |-> pin_init_n_o && !elevated_en_o;
    endproperty
    a_variant: assert property (p_variant)
        else $error("init pin used on variant without it");
endmodule

// file: logic/fbo_timer.sv
// Down counter that times each pin phase.
// Assumes a load is given one cycle before the timed phase starts.
module fbo_timer
    import fbo_pkg::*;
(
    input  wire logic clk_i,  // 40 MHz clock
    input  wire logic rst_i,  // Async reset, high
    fbo_tmr_if.tmr    tmr     // Load and done
);
    import fbo_pkg::*;
    fbo_cnt_t cnt_q;
    fbo_cnt_t cnt_d;

    ////////////////////////////////////////////////////////////////////
    // Next count: a wait of N cycles runs N-1 down to 0
    always_comb begin
        cnt_d = cnt_q;
        if (tmr.load) begin
            cnt_d = tmr.cycles - 8'h01;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Done reads the count alone: load is built from done, so a term in
    // load here would close a combinational loop
    assign tmr.done = (cnt_q == 8'h00);
endmodule

// file: pkg/fbo_pkg.sv
// Constants and types of the parallel flash bus host.
// Assumes one 40 MHz clock and a byte-wide asynchronous flash on the pins.
//
// Contract
// - Read: select and output enable low, write enable and init high.
// - Write: write enable and select low, output enable and init high.
// - Leaving standby, host waits the full select access time for data.
// - Host reissues an operation cut off by an init pulse; fbo_host does not, the bench reissues it.
// - Host polls status with ordinary reads during program or erase; fbo_host does not poll, the bench waits 30 cycles.
// - Program and erase need the unlock writes before them.
package fbo_pkg;
    localparam int ADDR_W          = 18;
    localparam int DATA_W          = 8;
    localparam int CNT_W           = 8;
    localparam int CLK_PERIOD_NS   = 25;
    // Least times, rounded up to whole cycles
    localparam int SEL_ACCESS_NS   = 90;
    localparam int SEL_ACCESS_CYC  =
        (SEL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_PULSE_NS     = 50;
    localparam int WE_PULSE_CYC    =
        (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_PULSE_NS   = 500;
    localparam int INIT_PULSE_CYC  =
        (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_RECOVER_NS = 50;
    localparam int INIT_RECOVER_CYC =
        (INIT_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_RECOVER_CYC  = 1;
    // Unlock write pair placed before a guarded command
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 18'h00001;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_1 = 8'ha5;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 18'h00002;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_2 = 8'h5a;

    typedef logic [ADDR_W-1:0] fbo_addr_t;
    typedef logic [DATA_W-1:0] fbo_data_t;
    typedef logic [CNT_W-1:0]  fbo_cnt_t;
endpackage

// file: pkg/fbo_tmr_if.sv
// Link between the host sequencer and its cycle timer.
// Assumes both ends share clk_i.
interface fbo_tmr_if;
    import fbo_pkg::*;
    logic      load;    // Start a wait
    fbo_cnt_t  cycles;  // Length of the wait in cycles
    logic      done;    // Last cycle of the wait
    modport ctl (output load, output cycles, input done);
    modport tmr (input load, input cycles, output done);
endinterface

// file: verification/fbo_flash_model.sv
// Behavioural byte-wide flash seen from the host's pins.
// Assumes pins change on clk_i rising edges; it samples them on falling.
module fbo_flash_model
    import fbo_pkg::*;
#(
    parameter fbo_data_t ID_CODE  = 8'h6b, // Arbitrary identifier value
    parameter int        BUSY_CYC = 20     // Program time in clocks
) (
    input  wire logic      clk_i,     // Bench clock
    input  wire logic      cs_n_i,    // Select, low
    input  wire logic      oe_n_i,    // Output enable, low
    input  wire logic      we_n_i,    // Write enable, low
    input  wire logic      init_n_i,  // Init pin, low
    input  wire logic      elev_i,    // Init pin at elevated level
    input  wire fbo_addr_t addr_i,    // Address pins
    input  wire fbo_data_t host_d_i,  // Host data on the wire
    input  wire logic      host_oe_i, // Host drives the wire
    output fbo_data_t      dq_o,      // Resolved data wire
    output logic          clash_o    // Both sides drive the wire
);
    timeunit 1ns;
    timeprecision 1ps;
    fbo_data_t  mem [256];
    fbo_data_t  last_q, la, ld, pd, rd;
    fbo_addr_t  pa;
    logic [1:0] step, mode;
    logic       drive, wa, wa_q;
    int         busy;
    ////////////////////////////////////////////////////////////////////////
    // Array after power-up reads a known pattern in array mode
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
        step = 0;
        mode = 0;
        busy = 0;
        wa_q = 0;
        last_q = 8'h00;
    end
    // Drive only in a clean read; init pin outranks select and enables
    assign drive = init_n_i && !cs_n_i && !oe_n_i && we_n_i;
    assign rd = busy > 0 ? ~pd : mode == 1 ? ID_CODE : mem[addr_i[7:0]];
    assign dq_o = host_oe_i ? host_d_i : drive ? rd : ~last_q;
    assign clash_o = host_oe_i && drive;
    assign wa = !cs_n_i && !we_n_i && init_n_i;
    always @(posedge clk_i) last_q <= dq_o;
    ////////////////////////////////////////////////////////////////////////
    // Command latch, unlock tracking, program timer and init abort
    always @(negedge clk_i) begin
        wa_q <= wa;
        if (!init_n_i) begin
            busy <= 0;
            mode <= 0;
            step <= 0;
        end else begin
            if (busy > 0) busy <= busy - 1;
            if (busy == 1) mem[pa[7:0]] <= pd;
            if (wa) begin
                la <= addr_i;
                ld <= host_d_i;
            end
            if (wa_q && !wa) begin
                if (mode == 2) begin
                    if (!la[7] || elev_i) begin
                        pa <= la;
                        pd <= ld;
                        busy <= BUSY_CYC;
                    end
                    mode <= 0;
                end else if (ld == 8'hf0) mode <= 0;
                else if (step == 2 && ld == 8'h90) mode <= 1;
                else if (step == 2 && ld == 8'ha0) mode <= 2;
                step <= (la == UNLOCK_ADDR_1 && ld == UNLOCK_DATA_1) ? 2'd1 :
                    (step == 1 && la == UNLOCK_ADDR_2 &&
                     ld == UNLOCK_DATA_2) ? 2'd2 : 2'd0;
            end
        end
    end
endmodule

// file: verification/fbo_host_tb.sv
// Self-checking bench of the flash host against the flash model.
// Assumes a 40 MHz clock and pins sampled on falling edges.
module fbo_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fbo_pkg::*;
    typedef struct {
        logic w, u; fbo_addr_t a; fbo_data_t d; int gap; fbo_data_t e;
    } fbo_row_s;
    logic clk_i, rst_i, req_i, req_write_i, req_unlock_i;
    logic init_req_i, unprotect_i, req_ready_o, rvalid_o, init_done_o;
    logic elevated_en_o, cs_n, oe_n, we_n, init_n, d_oe, clash;
    fbo_addr_t req_addr_i, addr;
    fbo_data_t req_wdata_i, rdata_o, d_in, d_out, r;
    int fails, cmp_count, viol, ilow, lat;
    logic ni_ready, ni_init_n, ni_elev;
    fbo_row_s rows [12] = '{
        '{0, 0, 18'h05, 8'h00, 0, 8'h39}, '{1, 1, 18'h01, 8'ha0, 0, 8'h00},
        '{1, 0, 18'h10, 8'h77, 0, 8'h00}, '{0, 0, 18'h10, 8'h00, 30, 8'h88},
        '{0, 0, 18'h10, 8'h00, 0, 8'h77}, '{1, 1, 18'h01, 8'h90, 0, 8'h00},
        '{0, 0, 18'h00, 8'h00, 0, 8'h6b}, '{1, 0, 18'h00, 8'hf0, 0, 8'h00},
        '{0, 0, 18'h05, 8'h00, 0, 8'h39}, '{1, 1, 18'h01, 8'ha0, 0, 8'h00},
        '{1, 0, 18'h90, 8'h11, 30, 8'h00}, '{0, 0, 18'h90, 8'h00, 0, 8'hac}};
    fbo_host dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_unlock_i(req_unlock_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .init_req_i(init_req_i), .init_done_o(init_done_o),
        .unprotect_i(unprotect_i), .elevated_en_o(elevated_en_o),
        .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
        .write_enable_n_o(we_n), .pin_init_n_o(init_n), .addr_in_o(addr),
        .data_io_i(d_in), .data_io_o(d_out), .data_io_oe_o(d_oe));
    fbo_flash_model flash (.clk_i(clk_i), .cs_n_i(cs_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .init_n_i(init_n), .elev_i(elevated_en_o),
        .addr_i(addr), .host_d_i(d_out), .host_oe_i(d_oe), .dq_o(d_in),
        .clash_o(clash));
    // Second host built for the flash variant without the init pin
    fbo_host #(.HAS_INIT_PIN(1'b0)) dut_ni (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(req_i), .req_write_i(req_write_i),
        .req_unlock_i(req_unlock_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_ready_o(ni_ready), .rdata_o(),
        .rvalid_o(), .init_req_i(init_req_i), .init_done_o(),
        .unprotect_i(unprotect_i), .elevated_en_o(ni_elev),
        .chip_select_n_o(), .output_enable_n_o(), .write_enable_n_o(),
        .pin_init_n_o(ni_init_n), .addr_in_o(), .data_io_i(d_in),
        .data_io_o(), .data_io_oe_o());
    ////////////////////////////////////////////////////////////////////////
    // Clock and pin watch: write pattern, bus fights, init low time
    initial begin
        clk_i = 0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        if (!rst_i && !cs_n && !we_n && !(oe_n && init_n)) viol++;
        if (!rst_i && (clash || (!cs_n && !oe_n && !we_n))) viol++;
        if (init_n === 1'b0) ilow++;
        if (!rst_i && (ni_init_n !== 1'b1 || ni_elev !== 1'b0)) viol++;
    end
    ////////////////////////////////////////////////////////////////////////
    // Compare tasks, transfers and the closing task
    task automatic chk_d(input fbo_data_t got, input fbo_data_t exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic u, input fbo_addr_t a,
                        input fbo_data_t d);
        int n;
        n = 0;
        @(posedge clk_i);
        req_i <= 1;
        req_write_i <= w;
        req_unlock_i <= u;
        req_addr_i <= a;
        req_wdata_i <= d;
        do @(negedge clk_i); while (req_ready_o !== 1'b1 && ++n < 100);
        @(posedge clk_i);
        req_i <= 0;
        lat = 0;
        do begin
            @(negedge clk_i);
            lat++;
        end while ((w ? req_ready_o : rvalid_o) !== 1'b1 && lat < 50);
        r = rdata_o;
        if (n == 100 || lat == 50) fails++;
    endtask
    task automatic init_pulse();
        int hi;
        hi = 0;
        @(posedge clk_i);
        init_req_i <= 1;
        @(posedge clk_i);
        init_req_i <= 0;
        ilow = 0;
        lat = 0;
        do begin
            @(negedge clk_i);
            lat++;
            if (init_done_o !== 1'b1 && req_ready_o !== 1'b0) hi++;
            if (ni_ready !== 1'b1) hi++;
        end while (init_done_o !== 1'b1 && lat < 50);
        chk_n(lat, 23);
        chk_n(ilow, INIT_PULSE_CYC);
        chk_n(hi, 0);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the expected run length
    initial begin
        #(CLK_PERIOD_NS * 20000);
        fails++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, table of accesses, then awkward cases
    initial begin
        {rst_i, req_i, req_write_i, req_unlock_i} = 4'b1000;
        {init_req_i, unprotect_i} = 2'b00;
        req_addr_i = '0;
        req_wdata_i = 8'h00;
        {fails, cmp_count, viol, ilow} = '0;
        repeat (8) @(posedge clk_i);
        chk_d({2'b00, cs_n, oe_n, we_n, init_n, d_oe, rvalid_o}, 8'h3c);
        rst_i <= 0;
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].u, rows[i].a, rows[i].d);
            if (rows[i].w) chk_n(lat, rows[i].u ? 10 : 4);
            else chk_d(r, rows[i].e);
            if (!rows[i].w) chk_n(lat, SEL_ACCESS_CYC + 1);
            repeat (rows[i].gap) @(posedge clk_i);
        end
        // Init pulse cuts off a program; the bench then issues it again
        xfer(1, 1, UNLOCK_ADDR_1, 8'ha0);
        xfer(1, 0, 18'h20, 8'h44);
        init_pulse();
        xfer(0, 0, 18'h20, 8'h00);
        chk_d(r, 8'h1c);
        xfer(1, 1, UNLOCK_ADDR_1, 8'ha0);
        xfer(1, 0, 18'h20, 8'h44);
        repeat (30) @(posedge clk_i);
        xfer(0, 0, 18'h20, 8'h00);
        chk_d(r, 8'h44);
        // Temporary unprotect opens the guarded half, removal closes it
        @(posedge clk_i);
        unprotect_i <= 1;
        repeat (2) @(negedge clk_i);
        chk_d({6'h00, ni_elev, elevated_en_o}, 8'h01);
        xfer(1, 1, UNLOCK_ADDR_1, 8'ha0);
        xfer(1, 0, 18'h90, 8'h11);
        repeat (30) @(posedge clk_i);
        xfer(0, 0, 18'h90, 8'h00);
        chk_d(r, 8'h11);
        @(posedge clk_i);
        unprotect_i <= 0;
        repeat (2) @(negedge clk_i);
        chk_d({7'h00, elevated_en_o}, 8'h00);
        xfer(1, 1, UNLOCK_ADDR_1, 8'ha0);
        xfer(1, 0, 18'h91, 8'h22);
        repeat (30) @(posedge clk_i);
        xfer(0, 0, 18'h91, 8'h00);
        chk_d(r, 8'had);
        chk_n(viol, 0);
        results();
    end
endmodule
